// File: rtl/radio_cfg_params.svh
`ifndef RADIO_CFG_PARAMS_SVH
`define RADIO_CFG_PARAMS_SVH
`define ADDR_MAIN_MODE_BAND      5'h00
`define ADDR_DATA_MOD_CTRL       5'h01
`define ADDR_FSK_DEVIATION       5'h02
`define ADDR_BITRATE_C           5'h03
`define ADDR_BITRATE_D           5'h04
`define ADDR_MAIN_LAST           5'h0b
`define ADDR_IRQ_FIRST           5'h0c
`define ADDR_IRQ_LAST            5'h0f
`define ADDR_PKT_FIRST           5'h1c
`define RST_MAIN_MODE_BAND       8'h30
`define RST_DATA_MOD_CTRL        8'h24
`define RST_FSK_DEVIATION        8'h03
`define RST_BITRATE_C            8'h07
`define RST_BITRATE_D            8'h0f
`define BITRATE_D_MIN            8'h0f
`define FIFO_DEPTH               64
`endif

// File: rtl/radio_cfg_pkg.sv
`default_nettype none
package radio_cfg_pkg;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0, MODE_STANDBY = 3'h1, MODE_SYNTH = 3'h2, MODE_RX = 3'h3, MODE_TX = 3'h4
  } op_mode_t;
  typedef enum logic [1:0] {DATA_CONT = 2'h0, DATA_BUF = 2'h1, DATA_PKT = 2'h2} data_mode_t;
endpackage : radio_cfg_pkg
`default_nettype wire

// File: rtl/fifo_bus_if.sv
`default_nettype none
interface fifo_bus_if #(parameter int W = 8, parameter int AW = 6);
  logic          wr_en;
  logic [W-1:0]  wr_data;
  logic          rd_en;
  logic [W-1:0]  rd_data;
  logic          clear;
  logic          empty;
  logic          full;
  logic [AW:0]   count;
  modport ctrl (output wr_en, wr_data, rd_en, clear, input rd_data, empty, full, count);
  modport mem  (input wr_en, wr_data, rd_en, clear, output rd_data, empty, full, count);
endinterface : fifo_bus_if
`default_nettype wire

// File: rtl/packet_fifo_mem.sv
`default_nettype none
module packet_fifo_mem #(
  parameter int W  = 8,
  parameter int AW = 6
) (
  input  wire logic clk,
  input  wire logic rst_n,
  fifo_bus_if.mem   fb
);
  logic [W-1:0]  mem_q [2**AW];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic [W-1:0]  rd_q;
  logic          do_wr, do_rd;

  always_comb begin
    do_wr = fb.wr_en && (cnt_q != (AW+1)'(2**AW)) && !fb.clear;
    do_rd = fb.rd_en && (cnt_q != '0) && !fb.clear;
    wp_d  = fb.clear ? '0 : wp_q + AW'(do_wr);
    rp_d  = fb.clear ? '0 : rp_q + AW'(do_rd);
    cnt_d = fb.clear ? '0 : cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) mem_q[wp_q] <= fb.wr_data;
    if (do_rd) rd_q <= mem_q[rp_q];
  end

  assign fb.rd_data = rd_q;
  assign fb.count   = cnt_q;
  assign fb.empty   = (cnt_q == '0);
  assign fb.full    = (cnt_q == (AW+1)'(2**AW));
endmodule : packet_fifo_mem
`default_nettype wire

// File: rtl/radio_main_config_packet_fifo.sv
// Notes on behaviour
// RQ1: Tx start on non-empty FIFO clears leftover bytes after the packet.
// RQ2: Tx start by threshold keeps leftover bytes for following packets.
// RQ3: New reception waits until the host has emptied the FIFO.
// RQ4: Payload, address and CRC flags rise at last byte, hold until drained.
// RQ5: CRC result bit valid when CRC-good and payload flags rise.
// RQ6: In receive mode, CRC result clears once payload fully read.
// RQ7: Payload read in standby clears CRC result at next sync in receive.
// RQ8: Host keeps fill-method and fill bits default in packet mode.
// RQ9: Address groups: 0-11 main, 12-15 irq, 16-27 rx/tx/osc, 28-31 packet.
// RQ10: Mode bits 7-5 of address 0, reset standby.
// RQ11: Band bits 4-2 of address 0, reset code 100.
// RQ12: Sub-band bits 1-0 of address 0, reset 00.
// RQ13: Data mode bits 7-6 of address 1; 1X is packet mode.
// RQ14: Modulation bits 5-4 of address 1, reset FSK.
// RQ15: OOK threshold type bits 3-2 of address 1, reset peak.
// RQ16: IF gain bits 1-0 of address 1, reset 0 dB.
// RQ17: Address 2 holds deviation value, reset 0x03.
// RQ18: Addresses 3 and 4 hold bit rate coefficients C and D.
// RQ19: Host avoids undefined mode and band codes.
`include "radio_cfg_params.svh"
`default_nettype none
module radio_main_config_packet_fifo #(
  parameter int AW = 6
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  input  wire logic       host_fifo_wr,
  input  wire logic [7:0] host_fifo_wdata,
  input  wire logic       host_fifo_rd,
  output logic      [7:0] host_fifo_rdata,
  input  wire logic       tx_start_select,
  input  wire logic [7:0] payload_length,
  input  wire logic       tx_byte_take,
  output logic      [7:0] tx_byte,
  output logic            tx_done,
  input  wire logic       rx_sync_found,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_last_byte,
  input  wire logic       rx_addr_ok,
  input  wire logic       rx_crc_ok,
  output logic            rx_accept,
  output logic            payload_ready,
  output logic            addr_match,
  output logic            crc_good,
  output logic            crc_status,
  output logic            fifo_empty,
  output logic      [2:0] op_mode,
  output logic      [1:0] data_mode,
  output logic      [7:0] fsk_deviation,
  output logic      [7:0] bitrate_coeff_c,
  output logic      [7:0] bitrate_coeff_d
);
  fifo_bus_if #(.W(8), .AW(AW)) fb ();

  packet_fifo_mem #(.W(8), .AW(AW)) u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .fb    (fb)
  );

  logic [7:0] mmb_q;
  logic [7:0] mmb_d;
  logic [7:0] dmc_q;
  logic [7:0] dmc_d;
  logic [7:0] dev_q;
  logic [7:0] dev_d;
  logic [7:0] brc_q;
  logic [7:0] brc_d;
  logic [7:0] brd_q;
  logic [7:0] brd_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       hit_q;
  logic       hit_d;
  logic [1:0] dmode_q;
  logic [1:0] dmode_d;
  logic [7:0] txcnt_q;
  logic [7:0] txcnt_d;
  logic       txdone_q;
  logic       txdone_d;
  logic       txbusy_q;
  logic       txbusy_d;
  logic       pr_q;
  logic       pr_d;
  logic       am_q;
  logic       am_d;
  logic       cg_q;
  logic       cg_d;
  logic       cs_q;
  logic       cs_d;
  logic       stby_read_q;
  logic       stby_read_d;
  logic       rxact_q;
  logic       rxact_d;
  logic       acc_q;
  logic       acc_d;
  logic       in_rx;
  logic       in_tx;
  logic       tx_pop;
  logic       last_tx;
  logic       rx_push;
  logic       host_pop;

  // Register file and read port
  always_comb begin
    mmb_d = mmb_q;
    dmc_d = dmc_q;
    dev_d = dev_q;
    brc_d = brc_q;
    brd_d = brd_q;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_MAIN_MODE_BAND: mmb_d = reg_wdata; // RQ10 RQ11 RQ12
        `ADDR_DATA_MOD_CTRL:  dmc_d = reg_wdata; // RQ13 RQ14 RQ15 RQ16
        `ADDR_FSK_DEVIATION:  dev_d = reg_wdata; // RQ17
        `ADDR_BITRATE_C:      brc_d = reg_wdata; // RQ18
        `ADDR_BITRATE_D:      brd_d = reg_wdata; // RQ18
        default: ;
      endcase
    end
    dmode_d = dmc_d[7] ? radio_cfg_pkg::DATA_PKT : dmc_d[7:6]; // RQ13
    rdata_d = rdata_q;
    hit_d   = 1'b0;
    if (reg_rd) begin
      hit_d = 1'b1;
      case (reg_addr)
        `ADDR_MAIN_MODE_BAND: rdata_d = mmb_q;
        `ADDR_DATA_MOD_CTRL:  rdata_d = dmc_q;
        `ADDR_FSK_DEVIATION:  rdata_d = dev_q;
        `ADDR_BITRATE_C:      rdata_d = brc_q;
        `ADDR_BITRATE_D:      rdata_d = brd_q;
        default: begin
          rdata_d = 8'h00; // RQ9
          hit_d   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mmb_q   <= `RST_MAIN_MODE_BAND;
      dmc_q   <= `RST_DATA_MOD_CTRL;
      dev_q   <= `RST_FSK_DEVIATION;
      brc_q   <= `RST_BITRATE_C;
      brd_q   <= `RST_BITRATE_D;
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
      dmode_q <= radio_cfg_pkg::DATA_CONT;
    end else begin
      mmb_q   <= mmb_d;
      dmc_q   <= dmc_d;
      dev_q   <= dev_d;
      brc_q   <= brc_d;
      brd_q   <= brd_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
      dmode_q <= dmode_d;
    end
  end

  // Decoded mode and FIFO steering
  always_comb begin
    in_rx    = (mmb_q[7:5] == radio_cfg_pkg::MODE_RX);
    in_tx    = (mmb_q[7:5] == radio_cfg_pkg::MODE_TX);
    tx_pop   = in_tx && tx_byte_take && !fb.empty;
    last_tx  = tx_pop && (txcnt_q + 8'h01 >= payload_length);
    rx_push  = in_rx && acc_q && rx_byte_valid;
    host_pop = host_fifo_rd && !fb.empty && !tx_pop;
    fb.wr_en   = rx_push || (host_fifo_wr && !rx_push);
    fb.wr_data = rx_push ? rx_byte : host_fifo_wdata;
    fb.rd_en   = tx_pop || host_pop;
    fb.clear   = txdone_q && tx_start_select; // RQ1
  end

  // Transmit packet tracking
  always_comb begin
    txcnt_d  = txcnt_q;
    txdone_d = 1'b0;
    txbusy_d = txbusy_q;
    if (tx_pop) begin
      txbusy_d = 1'b1;
      txcnt_d  = txcnt_q + 8'h01;
    end
    if (last_tx) begin
      txdone_d = 1'b1;
      txbusy_d = 1'b0;
      txcnt_d  = 8'h00; // RQ2
    end
    if (!in_tx) begin
      txcnt_d  = 8'h00;
      txbusy_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txcnt_q  <= 8'h00;
      txdone_q <= 1'b0;
      txbusy_q <= 1'b0;
    end else begin
      txcnt_q  <= txcnt_d;
      txdone_q <= txdone_d;
      txbusy_q <= txbusy_d;
    end
  end

  // Receive flags and CRC result
  always_comb begin
    pr_d        = pr_q;
    am_d        = am_q;
    cg_d        = cg_q;
    cs_d        = cs_q;
    stby_read_d = stby_read_q;
    rxact_d     = rxact_q;
    acc_d       = acc_q;
    if (in_rx && rx_sync_found && fb.empty && !pr_q) begin
      acc_d   = 1'b1; // RQ3
      rxact_d = 1'b1;
      if (stby_read_q) begin
        cs_d        = 1'b0; // RQ7
        stby_read_d = 1'b0;
      end
    end
    if (pr_q && host_pop && fb.count == (AW+1)'(1)) begin
      pr_d = 1'b0; // RQ4
      am_d = 1'b0;
      cg_d = 1'b0;
      if (in_rx) cs_d = 1'b0; // RQ6
      else stby_read_d = 1'b1;
    end
    if (rx_push && rx_last_byte) begin
      pr_d    = 1'b1; // RQ4
      am_d    = rx_addr_ok;
      cg_d    = rx_crc_ok;
      cs_d    = rx_crc_ok; // RQ5
      acc_d   = 1'b0;
      rxact_d = 1'b0;
    end
    if (!in_rx) begin
      acc_d   = 1'b0;
      rxact_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pr_q        <= 1'b0;
      am_q        <= 1'b0;
      cg_q        <= 1'b0;
      cs_q        <= 1'b0;
      stby_read_q <= 1'b0;
      rxact_q     <= 1'b0;
      acc_q       <= 1'b0;
    end else begin
      pr_q        <= pr_d;
      am_q        <= am_d;
      cg_q        <= cg_d;
      cs_q        <= cs_d;
      stby_read_q <= stby_read_d;
      rxact_q     <= rxact_d;
      acc_q       <= acc_d;
    end
  end

  // Registered outputs
  logic [7:0] txb_q;
  logic       empty_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txb_q   <= 8'h00;
      empty_q <= 1'b1;
    end else begin
      txb_q   <= fb.rd_data;
      empty_q <= fb.empty;
    end
  end

  assign reg_rdata       = rdata_q;
  assign reg_hit         = hit_q;
  assign host_fifo_rdata = fb.rd_data;
  assign tx_byte         = txb_q;
  assign tx_done         = txdone_q;
  assign rx_accept       = acc_q;
  assign payload_ready   = pr_q;
  assign addr_match      = am_q;
  assign crc_good        = cg_q;
  assign crc_status      = cs_q;
  assign fifo_empty      = empty_q;
  assign op_mode         = mmb_q[7:5];
  assign data_mode       = dmode_q;
  assign fsk_deviation   = dev_q;
  assign bitrate_coeff_c = brc_q;
  assign bitrate_coeff_d = brd_q;
endmodule : radio_main_config_packet_fifo
`default_nettype wire

// File: tb/radio_cfg_asserts.sv
`default_nettype none
module radio_cfg_asserts (
  input wire logic       clk, rst_n, reg_wr, reg_rd, reg_hit, tx_start_select, tx_done,
  input wire logic       rx_sync_found, rx_last_byte, rx_byte_valid, rx_accept, host_fifo_rd, payload_ready,
  input wire logic       crc_good, crc_status, fifo_empty,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata, bitrate_coeff_c,
  input wire logic [2:0] op_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence tx_end_s;
    tx_done && tx_start_select;
  endsequence
  sequence rx_end_s;
    rx_accept && rx_byte_valid && rx_last_byte && op_mode == 3'h3;
  endsequence
  mode_write_a: assert property (reg_wr && reg_addr == 5'h00 |=> op_mode == $past(reg_wdata[7:5]))
    else $error("op_mode not updated");
  coeff_write_a: assert property (reg_wr && reg_addr == 5'h03 |=> bitrate_coeff_c == $past(reg_wdata))
    else $error("coeff c not updated");
  unmapped_read_a: assert property (reg_rd && reg_addr > 5'h04 |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  accept_rise_a: assert property ($rose(rx_accept) |-> $past(rx_sync_found) && !$past(payload_ready))
    else $error("reception started early");
  payload_set_a: assert property (rx_end_s |=> payload_ready && !rx_accept)
    else $error("payload flag missing");
  payload_hold_a: assert property (payload_ready && !host_fifo_rd && op_mode != 3'h4 |=> payload_ready)
    else $error("payload flag dropped");
  crc_valid_a: assert property ($rose(crc_good) |-> crc_status)
    else $error("crc status late");
  rx_clear_a: assert property ($fell(payload_ready) && op_mode == 3'h3 |-> !crc_status)
    else $error("crc status kept in rx");
  stby_keep_a: assert property ($fell(payload_ready) && op_mode == 3'h1 |-> crc_status == $past(crc_status))
    else $error("crc status lost in standby");
  tx_clear_a: assert property (tx_end_s |-> ##[1:3] fifo_empty)
    else $error("fifo kept after tx");
endmodule : radio_cfg_asserts
bind radio_main_config_packet_fifo radio_cfg_asserts i_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_hit,
  .tx_start_select, .tx_done, .rx_sync_found, .rx_last_byte, .rx_byte_valid, .rx_accept, .host_fifo_rd,
  .payload_ready,
  .crc_good, .crc_status, .fifo_empty, .reg_addr, .reg_wdata, .reg_rdata, .bitrate_coeff_c, .op_mode);
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            host_fifo_wr,
  output logic      [7:0] host_fifo_wdata,
  output logic            host_fifo_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_wr, reg_rd, host_fifo_wr, host_fifo_rd} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    host_fifo_wdata = 8'h00;
  end
  // Callers keep mode, band and fill codes legal
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clk);
    #1;
    {reg_wr, reg_rd, reg_wdata} = {2'h0, ~d};
  endtask : access
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    #1;
    {host_fifo_wr, host_fifo_wdata} = {1'b1, d};
    @(posedge clk);
    #1;
    {host_fifo_wr, host_fifo_wdata} = {1'b0, ~d};
  endtask : push
  task automatic pop();
    @(posedge clk);
    #1;
    host_fifo_rd = 1'b1;
    @(posedge clk);
    #1;
    host_fifo_rd = 1'b0;
  endtask : pop
endmodule : host_model
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, reg_wr, reg_rd, reg_hit, host_fifo_wr, host_fifo_rd, tx_start_select, tx_byte_take;
  logic       tx_done, rx_sync_found, rx_byte_valid, rx_last_byte, rx_addr_ok, rx_crc_ok, rx_accept;
  logic       payload_ready, addr_match, crc_good, crc_status, fifo_empty;
  logic [1:0] data_mode;
  logic [2:0] op_mode;
  logic [4:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, host_fifo_wdata, host_fifo_rdata, payload_length, tx_byte, rx_byte, d;
  logic [7:0] fsk_deviation, bitrate_coeff_c, bitrate_coeff_d;
  int         error_cnt, compares, seed, cyc, dones;
  radio_main_config_packet_fifo i_dut (.*);
  host_model i_host (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_done) dones <= dones + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  function automatic logic [7:0] pat(input int i);
    return 8'ha5 ^ 8'(i * 19);
  endfunction : pat
  function automatic logic [7:0] rst_val(input logic [4:0] r);
    logic [7:0] t [5] = '{8'h30, 8'h24, 8'h03, 8'h07, 8'h0f};
    return t[r];
  endfunction : rst_val
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic w1(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w1
  task automatic sync();
    rx_sync_found = 1'b1;
    w1(1);
    rx_sync_found = 1'b0;
  endtask : sync
  task automatic rx_bytes(input int n, input logic ok);
    {rx_crc_ok, rx_addr_ok} = {ok, ok};
    for (int i = 0; i < n; i++) begin
      {rx_byte_valid, rx_byte, rx_last_byte} = {1'b1, pat(i), i == n - 1};
      w1(1);
    end
    {rx_byte_valid, rx_last_byte, rx_byte} = {2'h0, 8'h5a};
    w1(1);
  endtask : rx_bytes
  task automatic pops(input int n, input int first);
    for (int i = first; i < n; i++) begin
      i_host.pop();
      chk("fifo_data", {1'b0, pat(i)}, {1'b0, host_fifo_rdata});
    end
    w1(2);
  endtask : pops
  task automatic tx_run(input logic sel, input logic exp_empty);
    tx_start_select = sel;
    for (int i = 0; i < 5; i++) i_host.push(pat(i));
    w1(1);
    for (int i = 0; i < 3; i++) begin
      tx_byte_take = 1'b1;
      w1(1);
      tx_byte_take = 1'b0;
      w1(1);
      chk("tx_byte", {1'b0, pat(i)}, {1'b0, tx_byte});
    end
    w1(4);
    chk("fifo_empty", {8'h0, exp_empty}, {8'h0, fifo_empty});
  endtask : tx_run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    {rst_n, tx_start_select, tx_byte_take, rx_sync_found, rx_byte_valid, rx_last_byte} = 6'h0;
    {rx_addr_ok, rx_crc_ok, rx_byte, payload_length} = {2'h0, 8'h00, 8'h03};
    {error_cnt, compares, cyc, dones, seed} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_58d8};
    w1(3);
    rst_n = 1'b1;
    for (int r = 0; r < 5; r++) begin
      i_host.access(1'b0, 5'(r), 8'h00);
      chk("reset_reg", {1'b1, rst_val(5'(r))}, {reg_hit, reg_rdata});
    end
    for (int k = 0; k < 24; k++) begin
      a = 5'($unsigned($random(seed)) % 5);
      d = 8'($random(seed));
      if (a == 5'h00) d = {3'(k % 3), 3'(k % 6), d[1:0]};
      if (a == 5'h04 && d < 8'h0f) d = 8'h0f;
      i_host.access(1'b1, a, d);
      i_host.access(1'b0, a, 8'h00);
      chk("reg_rw", {1'b1, d}, {reg_hit, reg_rdata});
      if (a == 5'h00) chk("op_mode", 9'(d[7:5]), 9'(op_mode));
      if (a == 5'h01) chk("data_mode", 9'(d[7] ? 2'h2 : d[7:6]), 9'(data_mode));
      if (a == 5'h02) chk("fsk_deviation", {1'b0, d}, {1'b0, fsk_deviation});
      if (a == 5'h03) chk("bitrate_coeff_c", {1'b0, d}, {1'b0, bitrate_coeff_c});
      if (a == 5'h04) chk("bitrate_coeff_d", {1'b0, d}, {1'b0, bitrate_coeff_d});
      i_host.access(1'b0, 5'h05 + 5'($unsigned($random(seed)) % 27), 8'h00);
      chk("unmapped", 9'h000, {reg_hit, reg_rdata});
    end
    i_host.access(1'b1, 5'h00, 8'h70);
    sync();
    rx_bytes(4, 1'b1);
    chk("rx_flags", 9'h00f, {5'h0, payload_ready, addr_match, crc_good, crc_status});
    sync();
    w1(1);
    chk("rx_accept", 9'h000, {8'h0, rx_accept});
    pops(4, 0);
    chk("rx_clear", 9'h000, {5'h0, payload_ready, addr_match, crc_good, crc_status});
    sync();
    rx_bytes(3, 1'b1);
    i_host.access(1'b1, 5'h00, 8'h30);
    pops(3, 0);
    chk("stby_crc", 9'h001, {7'h0, payload_ready, crc_status});
    i_host.access(1'b1, 5'h00, 8'h70);
    sync();
    w1(1);
    chk("sync_crc", 9'h002, {7'h0, rx_accept, crc_status});
    rx_bytes(2, 1'b0);
    chk("bad_crc", 9'h008, {5'h0, payload_ready, addr_match, crc_good, crc_status});
    pops(2, 0);
    i_host.access(1'b1, 5'h00, 8'h90);
    tx_run(1'b1, 1'b1);
    tx_run(1'b0, 1'b0);
    chk("tx_done", 9'h002, 9'(dones));
    i_host.access(1'b1, 5'h00, 8'h30);
    pops(5, 3);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
